// file: inc/slpg_pkg.sv
// constants of the lane self-test block: eye monitor and pattern generator
// assumes a 32-bit register port with byte addresses; bit 0 is the lsb
//
// Function
// - frequency offset field, bits 2 to 14
// - eye phase field, bits 21 to 30
// - sub-resolution bits at 15 and 31
// - measurement reads are pipelined, two reads needed
// - first read after write returns written value
// - mode field 29-31; 0 off, 1 lfsr15
// - mode 2 gives lfsr7 x^7+x^6+1
// - mode 3 repeats the pattern word
// - mode 4 alternates pattern word and inverse
// - mode 5 cycles zeros, word, ones, inverse
// - trigger bit 28 flips one output lsb
// - reset clears pattern, trigger and mode
package slpg_pkg;
   localparam logic [16:0] FP_OFS = 17'h1E074;
   localparam logic [16:0] CTL_OFS = 17'h1E0A0;
   localparam int FREQ_LSB = 2;
   localparam int FREQ_W = 13;
   localparam int FSUB_BIT = 15;
   localparam int PHASE_LSB = 21;
   localparam int PHASE_W = 10;
   localparam int PSUB_BIT = 31;
   localparam int PAT_LSB = 18;
   localparam int PAT_W = 10;
   localparam int TRIG_BIT = 28;
   localparam int MODE_LSB = 29;
   localparam int MODE_W = 3;
   localparam int MEAS_W = 25;
   localparam logic [31:0] FP_MASK = 32'hFFE0FFFC;
   localparam logic [31:0] FP_RST = 32'h00000000;
   localparam logic [31:0] CTL_RST = 32'h00000000;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_LFSR15 = 3'h1;
   localparam logic [2:0] MODE_LFSR7 = 3'h2;
   localparam logic [2:0] MODE_FIXED = 3'h3;
   localparam logic [2:0] MODE_DCBAL = 3'h4;
   localparam logic [2:0] MODE_QUAD = 3'h5;
   localparam logic [14:0] LFSR_SEED = 15'h7FFF;
   localparam logic [9:0] WORD_ONES = 10'h3FF;
   localparam logic [9:0] WORD_ZEROS = 10'h000;
   localparam int FIFO_DEPTH = 8;
endpackage

// file: logic/slpg_lane_test.sv
// lane self-test: pipelined eye monitor register and tx pattern generator
// assumes measurement inputs come from the transceiver, asynchronous to
// clock, and a serializer that drains 10-bit words with valid/ready
//
// Implementation choice: the address-and-strobe port.

////////////////////////////////////////////////////////////////////////////
module slpg_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
      logic ovalid;
      logic [W-1:0] odata;
   } slpg_fifo_s;
   slpg_fifo_s r, n;
   logic push;
   logic load;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      return (p == PW'(D - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   // output word is registered so the serializer never sees a mux path
   assign in_ready = (r.cnt != CW'(D));
   assign out_valid = r.ovalid;
   assign out_data = r.odata;

   always_comb begin
      n = r;
      push = in_valid && in_ready;
      load = (r.cnt != '0) && (!r.ovalid || out_ready);
      if (r.ovalid && out_ready) begin
         n.ovalid = 1'b0;
      end
      if (load) begin
         n.odata = r.mem[r.rp];
         n.ovalid = 1'b1;
         n.rp = ptr_inc(r.rp);
      end
      if (push) begin
         n.mem[r.wp] = in_data;
         n.wp = ptr_inc(r.wp);
      end
      n.cnt = CW'(r.cnt + CW'(push) - CW'(load));
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   fifo_bound_a: assert property (@(posedge clock) disable iff (sys_rst)
      r.cnt <= CW'(D)) else $error("fifo count beyond depth");
endmodule

////////////////////////////////////////////////////////////////////////////
module slpg_lane_test #(
   parameter int ADDR_W = 17,
   parameter int DEPTH = slpg_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [12:0] meas_freq,
   input wire logic meas_freq_sub,
   input wire logic [9:0] meas_phase,
   input wire logic meas_phase_sub,
   output logic [9:0] tx_word,
   output logic tx_valid,
   input wire logic tx_ready
);
   typedef struct packed {
      logic [31:0] rdata;
      logic [31:0] fp_hold;
      logic [2:0] mode;
      logic trig;
      logic [9:0] pat;
      logic pend;
      logic [14:0] lfsr;
      logic [1:0] idx;
      logic [slpg_pkg::MEAS_W-1:0] s1;
      logic [slpg_pkg::MEAS_W-1:0] s2;
      logic [slpg_pkg::MEAS_W-1:0] s3;
      logic [slpg_pkg::MEAS_W-1:0] meas;
   } slpg_state_s;
   slpg_state_s r, n;
   logic fp_sel;
   logic ctl_sel;
   logic ctl_wr;
   logic gen_valid;
   logic gen_ready;
   logic push;
   logic [9:0] gen_word;
   logic [14:0] gen_lfsr;
   logic [24:0] prbs;
   logic trig_rise;

   // fifteen-bit register, ten-bit shift per word; the short form uses the low 7 bits
   function automatic logic [24:0] prbs_step(input logic [14:0] s,
                                             input logic short_poly);
      logic [14:0] st;
      logic [9:0] w;
      logic fb;
      st = s;
      w = '0;
      fb = 1'b0;
      for (int i = 9; i >= 0; i--) begin
         fb = short_poly ? (st[6] ^ st[5]) : (st[14] ^ st[13]);
         st = {st[13:0], fb};
         w[i] = fb;
      end
      return {st, w};
   endfunction

   function automatic logic [31:0] pack_fp(input logic [24:0] m);
      return {m[24], m[23:14], 5'h00, m[13], m[12:0], 2'h0};
   endfunction

   assign fp_sel = (reg_addr == ADDR_W'(slpg_pkg::FP_OFS));
   assign ctl_sel = (reg_addr == ADDR_W'(slpg_pkg::CTL_OFS));
   assign ctl_wr = reg_wr && ctl_sel;
   assign reg_rdata = r.rdata;
   // only a fresh 0 to 1 edge arms an error; a held 1 arms nothing
   assign trig_rise = ctl_wr && reg_wdata[slpg_pkg::TRIG_BIT] && !r.trig;

   /////////////////////////////////////////////////////////////////////////
   // pattern word for the current step
   always_comb begin
      gen_valid = 1'b1;
      gen_lfsr = r.lfsr;
      gen_word = slpg_pkg::WORD_ZEROS;
      prbs = '0;
      case (r.mode)
         slpg_pkg::MODE_LFSR15: begin
            prbs = prbs_step(r.lfsr, 1'b0);
            gen_lfsr = prbs[24:10];
            gen_word = prbs[9:0];
         end
         slpg_pkg::MODE_LFSR7: begin
            prbs = prbs_step(r.lfsr, 1'b1);
            gen_lfsr = prbs[24:10];
            gen_word = prbs[9:0];
         end
         slpg_pkg::MODE_FIXED: begin
            gen_word = r.pat;
         end
         slpg_pkg::MODE_DCBAL: begin
            gen_word = r.idx[0] ? ~r.pat : r.pat;
         end
         slpg_pkg::MODE_QUAD: begin
            case (r.idx)
               2'h0: gen_word = slpg_pkg::WORD_ZEROS;
               2'h1: gen_word = r.pat;
               2'h2: gen_word = slpg_pkg::WORD_ONES;
               default: gen_word = ~r.pat;
            endcase
         end
         default: begin
            // off and the reserved codes send nothing
            gen_valid = 1'b0;
         end
      endcase
      if (r.pend) begin
         gen_word[0] = ~gen_word[0];
      end
   end

   assign push = gen_valid && gen_ready;

   /////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = r;
      // three-stage sampler; only the agreeing tail stages are trusted
      n.s1 = {meas_phase_sub, meas_phase, meas_freq_sub, meas_freq};
      n.s2 = r.s1;
      n.s3 = r.s2;
      if (r.s2 == r.s3) begin
         n.meas = r.s3;
      end
      n.rdata = '0;
      if (reg_rd && fp_sel) begin
         // answer with the held word, then refill from the live sample
         n.rdata = r.fp_hold;
         n.fp_hold = pack_fp(r.meas);
      end else if (reg_rd && ctl_sel) begin
         n.rdata[slpg_pkg::MODE_LSB +: slpg_pkg::MODE_W] = r.mode;
         n.rdata[slpg_pkg::TRIG_BIT] = r.trig;
         n.rdata[slpg_pkg::PAT_LSB +: slpg_pkg::PAT_W] = r.pat;
      end
      if (reg_wr && fp_sel) begin
         n.fp_hold = reg_wdata & slpg_pkg::FP_MASK;
      end
      if (push) begin
         n.lfsr = gen_lfsr;
         n.idx = r.idx + 2'h1;
      end
      // a new edge always wins over the clear by the word that used it
      n.pend = r.pend && !push;
      if (ctl_wr) begin
         n.mode = reg_wdata[slpg_pkg::MODE_LSB +: slpg_pkg::MODE_W];
         n.trig = reg_wdata[slpg_pkg::TRIG_BIT];
         n.pat = reg_wdata[slpg_pkg::PAT_LSB +: slpg_pkg::PAT_W];
         n.lfsr = slpg_pkg::LFSR_SEED;
         n.idx = 2'h0;
         if (reg_wdata[slpg_pkg::TRIG_BIT] && !r.trig) begin
            n.pend = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.lfsr <= slpg_pkg::LFSR_SEED;
      end else begin
         r <= n;
      end
   end

   /////////////////////////////////////////////////////////////////////////
   slpg_fifo #(
      .W(10),
      .D(DEPTH)
   ) u_fifo (
      .clock(clock),
      .sys_rst(sys_rst),
      .in_valid(gen_valid),
      .in_ready(gen_ready),
      .in_data(gen_word),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_word)
   );

   /////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence fp_write_s;
      reg_wr && fp_sel;
   endsequence
   sequence fp_read_s;
      reg_rd && fp_sel;
   endsequence

   wr_then_rd_a: assert property (
      fp_write_s ##1 fp_read_s |=>
      reg_rdata == ($past(reg_wdata, 2) & slpg_pkg::FP_MASK))
      else $error("first read after write not the written word");

   live_read_a: assert property (
      fp_read_s ##1 fp_read_s |=> reg_rdata == pack_fp($past(r.meas, 2)))
      else $error("second read not the sampled measurement");

   fp_reserved_a: assert property (
      fp_read_s |=> reg_rdata[1:0] == 2'h0 && reg_rdata[20:16] == 5'h00)
      else $error("reserved measurement bits not zero");

   ctl_read_a: assert property (
      reg_rd && ctl_sel && !$past(ctl_wr) |=>
      reg_rdata == {$past(r.mode), $past(r.trig), $past(r.pat), 18'h00000})
      else $error("control read mismatch");

   fixed_word_a: assert property (
      push && r.mode == slpg_pkg::MODE_FIXED && !r.pend |-> gen_word == r.pat)
      else $error("fixed mode word differs from pattern");

   dc_balance_a: assert property (
      push && r.mode == slpg_pkg::MODE_DCBAL && !r.pend ##1
      push && !r.pend && !$past(ctl_wr) |-> gen_word == ~$past(gen_word))
      else $error("balanced mode did not invert");

   quad_ones_a: assert property (
      push && r.mode == slpg_pkg::MODE_QUAD && r.idx == 2'h2 && !r.pend
      |-> gen_word == slpg_pkg::WORD_ONES)
      else $error("quad mode third word not all ones");

   // a pending error may wait forever in mode 0, so no bound is asserted;
   // instead its arming, its source and its single use are each checked on their own
   sequence pend_spent_s;
      r.pend && push && !trig_rise;
   endsequence

   err_once_a: assert property (
      pend_spent_s |=> !r.pend)
      else $error("error injection not single");

   err_arm_a: assert property (
      trig_rise |=> r.pend)
      else $error("trigger edge did not arm an error");

   err_source_a: assert property (
      !r.pend ##1 r.pend |-> $past(trig_rise))
      else $error("error armed without a trigger edge");

   disabled_a: assert property (
      r.mode == slpg_pkg::MODE_OFF || r.mode > slpg_pkg::MODE_QUAD
      |-> !gen_valid)
      else $error("generator active while disabled");

   ctl_reserved_a: assert property (
      reg_rd && ctl_sel |=> reg_rdata[17:0] == 18'h00000)
      else $error("reserved control bits not zero");

   rdata_idle_a: assert property (
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data outside a read cycle");

   // own disable: this one has to look through the reset itself
   reset_clear_a: assert property (
      @(posedge clock) disable iff (1'b0)
      sys_rst |=> r.mode == slpg_pkg::MODE_OFF && !r.trig && r.pat == '0)
      else $error("reset left generator fields set");

   // a stalled fifo must freeze the sequence, not skip words
   lfsr_hold_a: assert property (
      !push && !ctl_wr |=> $stable(r.lfsr))
      else $error("lfsr advanced without a pushed word");

   idx_restart_a: assert property (
      ctl_wr |=> r.idx == 2'h0)
      else $error("sequence index not restarted by a control write");
endmodule

// file: tb/slpg_ser_model.sv
// serializer stand-in: drains 10-bit words from the lane test block
// assumes the bench reads got and steers hold and jitter

////////////////////////////////////////////////////////////////////////////
module slpg_ser_model (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [9:0] tx_word,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic hold,
   input wire logic jitter
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] got[$];
   // random ready gaps show whether the pattern stalls without skipping
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_ready <= 1'b0;
      end else begin
         if (tx_valid && tx_ready) got.push_back(tx_word);
         tx_ready <= !hold && (!jitter || ($urandom % 3 != 0));
      end
   end
endmodule

// file: tb/slpg_lane_test_bench.sv
// bench for the lane self-test block: register port, generator stream
// assumes the serializer model and a 100 MHz clock made here

////////////////////////////////////////////////////////////////////////////
`define chk(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   error_cnt++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end

module slpg_lane_test_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
   logic [16:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, d, d2, w;
   logic [12:0] meas_freq = 0;
   logic [9:0] meas_phase = 0, tx_word, e, p;
   logic meas_freq_sub = 0, meas_phase_sub = 0, tx_valid, tx_ready;
   logic hold = 0, jitter = 1, ok;
   logic b[$];
   int error_cnt = 0, cmp_count = 0;
   localparam logic [16:0] CTL = slpg_pkg::CTL_OFS;
   localparam logic [16:0] FP = slpg_pkg::FP_OFS;

   slpg_lane_test DUT (.clock(clock), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_freq(meas_freq),
      .meas_freq_sub(meas_freq_sub), .meas_phase(meas_phase),
      .meas_phase_sub(meas_phase_sub), .tx_word(tx_word),
      .tx_valid(tx_valid), .tx_ready(tx_ready));
   slpg_ser_model ser (.clock(clock), .sys_rst(sys_rst), .tx_word(tx_word),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .hold(hold),
      .jitter(jitter));

   initial begin
      forever #5 clock = ~clock;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [9:0] exp_word(logic [2:0] m, logic [9:0] pw,
                                           int i);
      case (m)
         3'h4: return (i % 2) ? ~pw : pw;
         3'h5: begin
            case (i % 4)
               0: return slpg_pkg::WORD_ZEROS;
               1: return pw;
               2: return slpg_pkg::WORD_ONES;
               default: return ~pw;
            endcase
         end
         default: return pw;
      endcase
   endfunction

   task wr(input logic [16:0] a, input logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [16:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      v = reg_rdata;
   endtask

   // write, then two back-to-back reads of the measurement word
   task fp_burst(input logic [31:0] v, output logic [31:0] d1,
                 output logic [31:0] dl);
      @(posedge clock);
      reg_addr <= FP;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(negedge clock);
      @(negedge clock);
      d1 = reg_rdata;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      dl = reg_rdata;
   endtask

   function automatic logic [31:0] exp_fp(logic [12:0] f, logic fs,
                                          logic [9:0] ph, logic ps);
      return {ps, ph, 5'h00, fs, f, 2'h0};
   endfunction

   // drain first so the new sequence starts from an empty fifo
   task run_mode(input logic [2:0] m, input logic [9:0] pw, input logic t,
                 input int n);
      int k;
      wr(CTL, 32'h0);
      repeat (40) @(posedge clock);
      ser.got.delete();
      hold <= 1'b1;
      wr(CTL, {m, t, pw, 18'h0});
      repeat (15) @(posedge clock);
      hold <= 1'b0;
      for (k = 0; k < 300 && ser.got.size() < n; k++) @(posedge clock);
   endtask

   task stop_test;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #100000;
      error_cnt++;
      stop_test;
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      w = $urandom(32'hAD2D);
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      rd(CTL, d);
      `chk("ctl reset", 32'h0, d)
      wr(CTL, 32'hEFFFFFFF);
      rd(CTL, d);
      `chk("ctl reserved", 32'hEFFC0000, d)
      wr(17'h1E078, 32'hFFFFFFFF);
      rd(17'h1E078, d);
      `chk("unmapped", 32'h0, d)
      repeat (3) begin
         @(posedge clock);
         w = $urandom;
         meas_freq <= 13'($urandom);
         meas_phase <= 10'($urandom);
         meas_freq_sub <= 1'($urandom);
         meas_phase_sub <= 1'($urandom);
         // the sampler needs four edges before a read can see the change
         repeat (6) @(posedge clock);
         fp_burst(w, d, d2);
         `chk("fp written", w & slpg_pkg::FP_MASK, d)
         w = exp_fp(meas_freq, meas_freq_sub, meas_phase, meas_phase_sub);
         `chk("fp live", w, d2)
      end
      for (int i = 0; i < 3; i++) begin
         run_mode(3'h0, 10'($urandom), 1'b0, 1);
         `chk("idle count", 0, ser.got.size())
         run_mode(3'(i + 5), 10'h2A5, 1'b0, 1);
         if (i > 0) `chk("resv count", 0, ser.got.size())
      end
      for (int m = 3; m < 6; m++) begin
         for (int r = 0; r < 4; r++) begin
            p = (r == 0) ? 10'h3FF : 10'($urandom);
            run_mode(3'(m), p, r[0], 12);
            for (int i = 0; i < 12; i++) begin
               e = exp_word(3'(m), p, i);
               if (r[0] && i == 0) e[0] = ~e[0];
               `chk("word", e, ser.got[i])
            end
         end
      end
      for (int m = 1; m < 3; m++) begin
         run_mode(3'(m), 10'h0, 1'b0, 6);
         b.delete();
         for (int i = 0; i < 6; i++)
            for (int k = 9; k >= 0; k--) b.push_back(ser.got[i][k]);
         ok = 1'b1;
         for (int n = 15; n < 60; n++) begin
            if (m == 1 && b[n] !== (b[n - 14] ^ b[n - 15])) ok = 1'b0;
            if (m == 2 && b[n] !== (b[n - 6] ^ b[n - 7])) ok = 1'b0;
         end
         `chk("lfsr", 1'b1, ok)
      end
      run_mode(3'h3, 10'h155, 1'b1, 2);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      `chk("valid rst", 1'b0, tx_valid)
      rd(CTL, d);
      `chk("ctl rerst", 32'h0, d)
      stop_test;
   end
endmodule
